/* File: pei_irq_ctrl.sv */
// Top of the PHY event interrupt control and status register.
// Assumes event detectors and the management port are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module pei_irq_ctrl (
    input  wire logic                          clk,                  // PHY clock, 25 MHz.
    input  wire logic                          rstn,                 // Async reset, active low.
    input  wire logic                          clk_en,               // Freezes state when low.
    input  wire logic [pei_pkg::ADDR_W-1:0]    mgmt_addr,            // Register address.
    input  wire logic                          mgmt_wr,              // Write strobe.
    input  wire logic [pei_pkg::DATA_W-1:0]    mgmt_wdata,           // Write data.
    input  wire logic                          mgmt_rd,              // Read strobe.
    output logic      [pei_pkg::DATA_W-1:0]    mgmt_rdata,           // Read data, registered.
    output logic                               mgmt_rvalid,          // Read data valid pulse.
    input  wire logic                          babble_det,           // Jabber pulse.
    input  wire logic                          rx_error_det,         // Receive error pulse.
    input  wire logic                          page_rcvd_det,        // New page pulse.
    input  wire logic                          par_detect_fault_det, // Parallel fault pulse.
    input  wire logic                          partner_ack_det,      // Acked FLP burst pulse.
    input  wire logic                          link_ok,              // Link status level.
    input  wire logic                          far_fault_det,        // Remote fault pulse.
    input  wire logic                          autoneg_done_det,     // Negotiation done pulse.
    output logic                               mac_raw_irq_status    // PHY interrupt request.
);
    import pei_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pei_flag_if        fif ();        // Link to the flag bank.
    logic [FLAG_W-1:0] enable_r;      // Interrupt enables, high byte.
    logic [FLAG_W-1:0] enable_nxt;    // Next enable value.
    logic              link_prev_r;   // Link status of the previous cycle.
    logic              link_fail_evt; // Link dropped this cycle.
    logic              rd_hit;        // Read of the event register.
    logic              wr_hit;        // Write of the event register.
    logic [DATA_W-1:0] reg_view;      // Register as it reads now.
    logic [DATA_W-1:0] rdata_nxt;     // Next read data.
    logic              irq_nxt;       // Next interrupt level.
    logic [FLAG_W-1:0] evt_vec;       // All events by flag position.

    // Address decode shared by read and write paths.
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a == EVT_REG_ADDR);
    endfunction : addr_hit

    // ------------------------------------------------------------------
    // Event collection
    // ------------------------------------------------------------------
    // falling link only.
    assign link_fail_evt = link_prev_r & ~link_ok;

    assign evt_vec[BABBLE_BIT]           = babble_det;
    assign evt_vec[RX_ERROR_BIT]         = rx_error_det;
    assign evt_vec[PAGE_RCVD_BIT]        = page_rcvd_det;
    assign evt_vec[PAR_DETECT_FAULT_BIT] = par_detect_fault_det;
    assign evt_vec[PARTNER_ACK_BIT]      = partner_ack_det;
    assign evt_vec[LINK_FAIL_BIT]        = link_fail_evt;
    assign evt_vec[FAR_FAULT_BIT]        = far_fault_det;
    assign evt_vec[AUTONEG_DONE_BIT]     = autoneg_done_det;

    // ------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------
    // decode at 0x11.
    assign rd_hit = mgmt_rd & addr_hit(mgmt_addr);
    assign wr_hit = mgmt_wr & addr_hit(mgmt_addr);

    // The events drive the flag bank's set lines and a host read of the event register drives its clear line through here.
    assign fif.set_req = evt_vec;
    assign fif.clr_all = rd_hit;

    // Current contents: enables above, flags below.
    assign reg_view   = {enable_r, fif.flags};
    // Unmapped addresses read as zero; the flags are returned before clearing.
    assign rdata_nxt  = rd_hit ? reg_view : UNMAPPED_DATA;
    assign enable_nxt = wr_hit ? mgmt_wdata[ENABLE_LSB +: FLAG_W] : enable_r;
    assign irq_nxt    = |(fif.flags & enable_r);

    // ------------------------------------------------------------------
    // Flag bank
    // ------------------------------------------------------------------
    pei_flag_bank u_flags (
        .clk    (clk),
        .rstn   (rstn),
        .clk_en (clk_en),
        .fif    (fif.bank)
    );

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    // Enables and link history; the write data low byte has no effect.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            enable_r    <= ENABLE_RESET;
            link_prev_r <= 1'b0;
        end else if (clk_en) begin
            enable_r    <= enable_nxt;
            link_prev_r <= link_ok;
        end
    end

    // Read answer: data and a one-cycle valid for any read strobe.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mgmt_rdata  <= EVT_REG_RESET;
            mgmt_rvalid <= 1'b0;
        end else if (clk_en) begin
            mgmt_rdata  <= rdata_nxt;
            mgmt_rvalid <= mgmt_rd;
        end
    end

    // Interrupt request toward the MAC raw interrupt status.
    // registered interrupt.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mac_raw_irq_status <= 1'b0;
        end else if (clk_en) begin
            mac_raw_irq_status <= irq_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // A clearing read with no events in the same step.
    sequence s_clear_read;
        clk_en && rd_hit && (evt_vec == FLAG_RESET);
    endsequence

    // A quiet step with no further events.
    sequence s_quiet;
        clk_en && !rd_hit && (evt_vec == FLAG_RESET);
    endsequence

    property p_read_clears;
        s_clear_read |=> (fif.flags == FLAG_RESET);
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("flags not cleared after register read");

    property p_sticky;
        clk_en && !rd_hit |=> ((fif.flags & $past(fif.flags)) == $past(fif.flags));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag dropped without a read");

    property p_set_wins;
        clk_en && rd_hit |=> ((fif.flags & $past(evt_vec)) == $past(evt_vec));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost in clearing read");

    property p_event_sets;
        clk_en |=> ((fif.flags & $past(evt_vec)) == $past(evt_vec));
    endproperty
    a_event_sets: assert property (p_event_sets)
        else $error("event did not set its flag");

    property p_link_fail;
        clk_en && link_prev_r && !link_ok |=> fif.flags[LINK_FAIL_BIT];
    endproperty
    a_link_fail: assert property (p_link_fail)
        else $error("link failure not flagged");

    property p_link_rise;
        clk_en && !link_prev_r && link_ok && !fif.flags[LINK_FAIL_BIT]
            |=> !fif.flags[LINK_FAIL_BIT];
    endproperty
    a_link_rise: assert property (p_link_rise)
        else $error("link recovery flagged as failure");

    property p_enable_write;
        clk_en && wr_hit |=> (enable_r == $past(mgmt_wdata[ENABLE_LSB +: FLAG_W]));
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable write not taken");

    property p_read_data;
        clk_en && rd_hit |=> mgmt_rvalid && (mgmt_rdata == {$past(enable_r), $past(fif.flags)});
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("wrong read data at event register");

    property p_irq_drop;
        s_clear_read ##1 s_quiet |=> !mac_raw_irq_status;
    endproperty
    a_irq_drop: assert property (p_irq_drop)
        else $error("interrupt stayed after clearing read");

    property p_irq_follows;
        clk_en && ((fif.flags & enable_r) != FLAG_RESET) |=> mac_raw_irq_status;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("enabled flag did not raise interrupt");

endmodule : pei_irq_ctrl

`default_nettype wire

/* File: pei_pkg.sv */
// Constants shared by the PHY event interrupt control block.
// Assumes a single PHY clock domain and a management register port.
`default_nettype none

package pei_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 5;                 // Management register address width.
    localparam int unsigned DATA_W = 16;                // Management register data width.
    localparam int unsigned FLAG_W = 8;                 // Number of event flags and enables.

    // ------------------------------------------------------------------
    // Register map and field layout
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] EVT_REG_ADDR  = 5'h11;   // Event control/status register.
    localparam logic [DATA_W-1:0] EVT_REG_RESET = 16'h0000; // Reset value of the register.
    localparam logic [FLAG_W-1:0] FLAG_RESET    = 8'h00;   // Reset value of the flags.
    localparam logic [FLAG_W-1:0] ENABLE_RESET  = 8'h00;   // Reset value of the enables.
    localparam logic [DATA_W-1:0] UNMAPPED_DATA = 16'h0000; // Read data of other addresses.
    localparam int unsigned FLAG_LSB   = 0;             // Low byte holds the flags.
    localparam int unsigned ENABLE_LSB = 8;             // High byte holds the enables.

    // ------------------------------------------------------------------
    // Flag bit positions
    // ------------------------------------------------------------------
    localparam int unsigned AUTONEG_DONE_BIT     = 0;   // Auto-negotiation complete.
    localparam int unsigned FAR_FAULT_BIT        = 1;   // Remote fault signalled.
    localparam int unsigned LINK_FAIL_BIT        = 2;   // Link went from good to failed.
    localparam int unsigned PARTNER_ACK_BIT      = 3;   // FLP burst with acknowledge.
    localparam int unsigned PAR_DETECT_FAULT_BIT = 4;   // Parallel detection fault.
    localparam int unsigned PAGE_RCVD_BIT        = 5;   // New page received.
    localparam int unsigned RX_ERROR_BIT         = 6;   // Receive error.
    localparam int unsigned BABBLE_BIT           = 7;   // Jabber on 10 Mb/s transmit.

endpackage : pei_pkg

`default_nettype wire

/* File: pei_flag_if.sv */
// Interface carrying set, clear and state of the event flag bank.
// Assumes both ends run on the same PHY clock.
`timescale 1ns/1ps
`default_nettype none

interface pei_flag_if;
    logic [pei_pkg::FLAG_W-1:0] set_req;   // One bit per event, high in the event cycle.
    logic                       clr_all;   // Clears every flag, set requests still win.
    logic [pei_pkg::FLAG_W-1:0] flags;     // Current sticky flag state.

    // The bank owns the flags and takes the requests.
    modport bank (input set_req, input clr_all, output flags);
    // The controller drives the requests and watches the flags.
    modport ctrl (output set_req, output clr_all, input flags);
endinterface : pei_flag_if

`default_nettype wire

/* File: pei_flag_bank.sv */
// Bank of eight sticky event flags with clear-on-read support.
// Assumes requests arrive as one-cycle pulses synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module pei_flag_bank (
    input  wire logic   clk,    // PHY clock.
    input  wire logic   rstn,   // Asynchronous reset, active low.
    input  wire logic   clk_en, // Freezes the flags while low.
    pei_flag_if.bank    fif     // Set, clear and state.
);
    import pei_pkg::*;

    // ------------------------------------------------------------------
    // Flag storage
    // ------------------------------------------------------------------
    logic [FLAG_W-1:0] flag_r;   // Sticky flags.
    logic [FLAG_W-1:0] flag_nxt; // Next flag value.

    // Each bit: a set in the clearing cycle keeps the flag alive.
    genvar i;
    generate
        for (i = 0; i < FLAG_W; i++) begin : g_flag
            assign flag_nxt[i] = fif.set_req[i] | (flag_r[i] & ~fif.clr_all);
        end
    endgenerate

    // Register the flags; hold everything while the clock enable is low.
    // sticky flag storage.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= FLAG_RESET;
        end else if (clk_en) begin
            flag_r <= flag_nxt;
        end
    end

    assign fif.flags = flag_r;

endmodule : pei_flag_bank

`default_nettype wire

/* File: pei_evt_model.sv */
// Far-side event detector model for the PHY event block.
// Assumes the bench changes req only at the falling edge of clk.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Event source
// ----------------------------------------------------------------
module pei_evt_model (
    input  wire logic [7:0] req,                  // One bit per event.
    output logic            babble_det,           // Jabber pulse.
    output logic            rx_error_det,         // Receive error pulse.
    output logic            page_rcvd_det,        // New page pulse.
    output logic            par_detect_fault_det, // Parallel fault pulse.
    output logic            partner_ack_det,      // Acked burst pulse.
    output logic            link_ok,              // Link level.
    output logic            far_fault_det,        // Remote fault pulse.
    output logic            autoneg_done_det      // Negotiation done pulse.
);
    // Pulse events follow their request bit for one cycle.
    assign {babble_det, rx_error_det, page_rcvd_det} = req[7:5];
    assign {par_detect_fault_det, partner_ack_det} = req[4:3];
    assign {far_fault_det, autoneg_done_det} = req[1:0];
    // The link is down while req[2] is high and recovers when it falls, so both edges occur.
    assign link_ok = ~req[2];
endmodule : pei_evt_model

`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the PHY event interrupt register.
// Assumes pei_pkg, pei_irq_ctrl and pei_evt_model are compiled first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end

module testbench;
    import pei_pkg::*;
    logic              clk, rstn, wr, rd, rvalid, irq, cen;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, q;
    logic [FLAG_W-1:0] req;
    logic              bd, re, pr, pf, pa, lk, ff, ad;
    int                miscompares, n_checks;

    pei_evt_model i_pei_evt_model (.req(req), .babble_det(bd), .rx_error_det(re),
        .page_rcvd_det(pr), .par_detect_fault_det(pf), .partner_ack_det(pa),
        .link_ok(lk), .far_fault_det(ff), .autoneg_done_det(ad));
    pei_irq_ctrl i_pei_irq_ctrl (.clk(clk), .rstn(rstn), .clk_en(cen),
        .mgmt_addr(addr), .mgmt_wr(wr), .mgmt_wdata(wdata), .mgmt_rd(rd),
        .mgmt_rdata(rdata), .mgmt_rvalid(rvalid), .babble_det(bd),
        .rx_error_det(re), .page_rcvd_det(pr), .par_detect_fault_det(pf),
        .partner_ack_det(pa), .link_ok(lk), .far_fault_det(ff),
        .autoneg_done_det(ad), .mac_raw_irq_status(irq));

    // Clock of 40 ns period.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Prints the counts and the verdict, then stops.
    task automatic test_done;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    // One-cycle write strobe.
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : reg_wr

    // host polling read
    // One-cycle read strobe, optionally with events in the same cycle.
    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [FLAG_W-1:0] ev);
        int n;
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        req = ev;
        @(negedge clk);
        rd = 1'b0;
        req = '0;
        n = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (n == 4) begin
            miscompares++;
            test_done();
        end
        q = rdata;
        `CHK(n, 0)
        @(negedge clk);
        `CHK(rvalid, 1'b0)
    endtask : reg_rd

    // One-cycle event request.
    task automatic pulse(input logic [FLAG_W-1:0] ev);
        @(negedge clk);
        req = ev;
        @(negedge clk);
        req = '0;
    endtask : pulse

    // Reset value and an unmapped address.
    task automatic t_reset;
        `CHK(irq, 1'b0)
        reg_rd(EVT_REG_ADDR, 8'h00);
        `CHK(q, EVT_REG_RESET)
        reg_rd(5'h12, 8'h00);
        `CHK(q, UNMAPPED_DATA)
    endtask : t_reset

    // Enables are read-write; flags ignore writes; other addresses ignored.
    task automatic t_enables;
        reg_wr(EVT_REG_ADDR, 16'h5aa5);
        reg_wr(5'h12, 16'hffff);
        reg_rd(EVT_REG_ADDR, 8'h00);
        `CHK(q, 16'h5a00)
        reg_wr(EVT_REG_ADDR, 16'hff00);
    endtask : t_enables

    // Each event sets its own flag, raises the interrupt, and read clears it.
    task automatic t_each;
        logic [FLAG_W-1:0] m;
        for (int i = 0; i < FLAG_W; i++) begin
            m = 8'h01 << i;
            pulse(m);
            @(negedge clk);
            `CHK(irq, 1'b1)
            reg_rd(EVT_REG_ADDR, 8'h00);
            `CHK(q, {8'hff, m})
            reg_rd(EVT_REG_ADDR, 8'h00);
            `CHK(q, 16'hff00)
            `CHK(irq, 1'b0)
        end
    endtask : t_each

    // Disabled flags stay latched but do not interrupt.
    task automatic t_mask;
        reg_wr(EVT_REG_ADDR, 16'h0100);
        pulse(8'hfe);
        repeat (5) @(negedge clk);
        `CHK(irq, 1'b0)
        reg_rd(EVT_REG_ADDR, 8'h00);
        `CHK(q, 16'h01fe)
        pulse(8'h01);
        @(negedge clk);
        `CHK(irq, 1'b1)
        reg_rd(EVT_REG_ADDR, 8'h00);
        `CHK(q, 16'h0101)
    endtask : t_mask

    // An event in the clearing read cycle survives the clear.
    task automatic t_overlap;
        reg_rd(EVT_REG_ADDR, 8'h40);
        `CHK(q, 16'h0100)
        reg_rd(EVT_REG_ADDR, 8'h00);
        `CHK(q, 16'h0140)
    endtask : t_overlap

    // A link held down across a clearing read and then recovering sets nothing new.
    task automatic t_link_rise;
        @(negedge clk);
        req = 8'h04;
        reg_rd(EVT_REG_ADDR, 8'h04);
        `CHK(q, 16'h0104)
        reg_rd(EVT_REG_ADDR, 8'h00);
        `CHK(q, 16'h0100)
    endtask : t_link_rise

    // With the clock enable low, events and writes leave no trace.
    task automatic t_freeze;
        @(negedge clk);
        cen = 1'b0;
        pulse(8'hff);
        reg_wr(EVT_REG_ADDR, 16'hff00);
        @(negedge clk);
        `CHK(irq, 1'b0)
        cen = 1'b1;
        reg_rd(EVT_REG_ADDR, 8'h00);
        `CHK(q, 16'h0100)
    endtask : t_freeze

    // Main sequence.
    initial begin
        miscompares = 0;
        n_checks = 0;
        rstn = 1'b0;
        cen = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = '0;
        wdata = '0;
        req = '0;
        repeat (8) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_enables();
        t_each();
        t_mask();
        t_overlap();
        t_link_rise();
        t_freeze();
        test_done();
    end
endmodule : testbench

`default_nettype wire
